//--- hw/gpb_map.vh
// register offsets, reset values and field positions of the general-purpose port bank
`ifndef GPB_MAP_VH
`define GPB_MAP_VH
`define GPB_OFS_P0_DATA   16'h0008
`define GPB_OFS_P0_DIR    16'h0009
`define GPB_OFS_P1_DATA   16'h000A
`define GPB_OFS_P1_DIR    16'h000B
`define GPB_OFS_P2_DATA   16'h000C
`define GPB_OFS_P2_DIR    16'h000D
`define GPB_OFS_P3_DATA   16'h000E
`define GPB_OFS_P3_DIR    16'h000F
`define GPB_OFS_PORT_CTL  16'h0010
`define GPB_OFS_P2_PULLUP 16'h0012
`define GPB_OFS_P6_DATA   16'h0014
`define GPB_OFS_P6_DIR    16'h0015
`define GPB_OFS_P5_DATA   16'h0016
`define GPB_OFS_P5_DIR    16'h0017
`define GPB_OFS_P4_DATA   16'h0018
`define GPB_OFS_P4_DIR    16'h0019
`define GPB_OFS_P7_DATA   16'h001A
`define GPB_OFS_P7_DIR    16'h001B
`define GPB_OFS_P8_DATA   16'h001C
`define GPB_OFS_P8_DIR    16'h001D
`define GPB_BASE_A        16'h0008
`define GPB_BASE_B        16'h0010
`define GPB_BASE_C        16'h0018
`define GPB_RST_VAL       8'h00
`define GPB_PTC_P2_LVL    6
`define GPB_MODE_SINGLE   2'h0
`define GPB_MODE_EXPAND   2'h1
`define GPB_MODE_MICRO    2'h2
`endif

//--- hw/gpb_port_bank.v
// general-purpose port bank with phase-clocked peripheral bus slave and pin muxing
// Functional notes
// R1: address low bits, read/write, valid strobe and select captured on phase one.
// R2: master drives read high, write low; valid strobe low for access; change on phase two.
// R3: data bus sampled on phase two: master on reads, register on writes.
// R4: each select plus three address bits decodes at most eight registers.
// R5: master drives write data from phase one; register takes it at next phase two.
// R6: on read, peripheral drives data bus after phase-one capture once decode done.
// R7: selects decoded combinationally from full address bus, no clock edge.
// R8: direction bit 1 makes pin output, 0 makes it input.
// R9: reset clears all direction registers to 00, all pins inputs.
// R10: reading an output bit returns the latch, not the pin.
// R11: writing an input bit updates only the latch, driver stays off.
// R12: second-function control sets pin direction instead of direction bit.
// R13: bus modes: ports 0,1 carry address, port 3 bits 0,3-7 bus control.
// R14: single chip: port 2 key-on wake-up; bus modes: port 2 is data bus.
// R15: port control bit 6 selects port 2 input threshold level.
// R16: port 4 bit 0 is bank strobe only in bus modes with bank enable.
// R17: port 4 bits 1,2 feed external interrupts with selectable polarity.
// R18: port 4 bit 3 carries first timer pin; interrupt source when not output.
// R19: port 4 bit 4 carries second timer input or pulse output.
// R20: sub-clock active removes port 5 bits 0,1; else bit 1 may be timer output.
// R21: port 5 bit 2 outputs outbuf full, bit 3 inverted inbuf full when enabled.
// R22: host control bit 6 makes port 5 bits 4-7 host input strobes.
// R23: two non-overlapping phase clocks, one pulse each per bus cycle.
`include "gpb_map.vh"
`default_nettype none
module gpb_port_bank #(
	parameter NPORT = 9
) (
	input  wire        mclk_in,            // system clock
	input  wire        rst_b_in,           // async reset, low active
	input  wire        clk_en_in,          // freezes all state when low
	input  wire        first_phase_clock_in,   // phase one strobe, same domain
	input  wire        second_phase_clock_in,  // phase two strobe, same domain
	input  wire [15:0] internal_address_bus_in, // full address
	input  wire        rd_wr_in,           // 1 read, 0 write
	input  wire        access_valid_n_in,  // low for valid access
	input  wire [7:0]  internal_data_bus_in, // write data from master
	output reg  [7:0]  internal_data_bus_out, // read data
	output reg         internal_data_bus_oe_out, // drives data bus
	input  wire [1:0]  proc_mode_in,       // processor mode
	input  wire        ext_bank_enable_in, // bank strobe enable
	input  wire        ext_bank_cycle_in,  // bank data cycle active
	input  wire [15:0] ext_addr_in,        // external address in bus modes
	input  wire [5:0]  ext_ctrl_in,        // port3 bits 0,3..7 control values
	input  wire [5:0]  ext_ctrl_oe_in,     // their drive enables
	input  wire [7:0]  ext_data_in,        // external data bus write value
	input  wire        ext_data_oe_in,     // external data bus drive
	input  wire        low_power_in,       // wait or stop state
	input  wire [1:0]  irq_enable_in,      // ext_irq_zero/one enables
	input  wire [1:0]  irq_polarity_in,    // 1 = active high
	input  wire        t1_out_mode_in,     // first timer in output mode
	input  wire        t1_pulse_in,        // first timer pulse
	input  wire        t1_polarity_in,     // first timer pin polarity
	input  wire        t1_irq_enable_in,   // first timer pin interrupt enable
	input  wire        t2_out_mode_in,     // second timer in output mode
	input  wire        t2_pulse_in,        // second timer pulse
	input  wire        sub_clock_on_in,    // sub-clock oscillator active
	input  wire        t12_out_en_in,      // combined timer output enable
	input  wire        t12_pulse_in,       // combined timer pulse
	input  wire [7:0]  host_if_ctrl_in,    // host interface control bits
	input  wire        host_outbuf_full_in, // host out buffer full
	input  wire        host_inbuf_full_in, // host in buffer full
	input  wire [71:0] pin_in,             // pin levels, port n in bits 8n+7..8n
	output reg  [71:0] pin_out,            // pin drive values
	output reg  [71:0] pin_oe_out,         // pin drive enables
	output reg  [7:0]  ext_data_out,       // port2 pins sampled in every mode
	output reg  [1:0]  ext_irq_out,        // ext_irq_zero/one requests
	output reg         t1_irq_out,         // first timer pin interrupt
	output reg         t1_pin_out,         // first_timer_pin level to timer
	output reg         t2_pin_out,         // second_timer_pin level to timer
	output reg         wake_out,           // key-on wake-up request
	output reg         p2_cmos_level_out,  // port2 threshold select
	output reg  [7:0]  p2_pullup_out,      // port2 pull-up enables
	output reg  [3:0]  host_strobes_out    // select_n, addr, rd_n, wr_n
);
	reg [71:0] sync1_q;
	reg [71:0] pin_s_q;
	reg [7:0]  data_q [0:NPORT-1];
	reg [7:0]  dir_q  [0:NPORT-1];
	reg [7:0]  ptc_q;
	reg [7:0]  pup_q;
	reg [2:0]  cap_addr_q;
	reg        cap_rd_q;
	reg        cap_val_n_q;
	reg [2:0]  cap_sel_n_q;

	// strobes are levels on this clock, so an edge detect is enough
	reg        ph1_d1_q;
	reg        ph2_d1_q;
	wire       ph1_rise = first_phase_clock_in & ~ph1_d1_q;
	wire       ph2_rise = second_phase_clock_in & ~ph2_d1_q;

	reg  [2:0] sel_n;
	reg  [3:0] port_idx;
	reg        is_dir;
	reg        hit;
	reg  [7:0] rd_val;

	reg  [71:0] fn_en;
	reg  [71:0] fn_val;
	reg  [71:0] fn_oe;
	wire       bus_mode = (proc_mode_in == `GPB_MODE_EXPAND) |
			(proc_mode_in == `GPB_MODE_MICRO);
	wire [71:0] lat_flat;
	wire [71:0] dir_flat;
	genvar gi;
	integer i;

	wire [7:0]  key_low;
	wire        wr_go;
	wire        rd_go;
	wire [1:0]  irq_lvl;

	// key-on: any input bit of port 2 pulled low counts as a key
	assign key_low = ~pin_s_q[23:16] & ~dir_q[2];  // R14
	// a write lands only on the phase-two rise of a valid captured write
	assign wr_go = ph2_rise && !cap_val_n_q && !cap_rd_q;  // R3 R5
	// drive drops on phase two so the bus is free for the next address
	assign rd_go = !cap_val_n_q && cap_rd_q && (cap_sel_n_q != 3'h7) && !ph2_rise;  // R6
	// polarity bit 1 means active high
	assign irq_lvl = ~(pin_s_q[34:33] ^ irq_polarity_in);  // R17

	// bases kept 16 bits wide so the compare can slice them
	localparam [15:0] BASE_A = `GPB_BASE_A;
	localparam [15:0] BASE_B = `GPB_BASE_B;
	localparam [15:0] BASE_C = `GPB_BASE_C;

	// selects from the whole address, no clock; each covers eight registers
	always @*
	begin
		sel_n = 3'h7;
		if (internal_address_bus_in[15:3] == BASE_A[15:3])  // R7 R4
			sel_n[0] = 1'b0;
		if (internal_address_bus_in[15:3] == BASE_B[15:3])  // R7 R4
			sel_n[1] = 1'b0;
		if (internal_address_bus_in[15:3] == BASE_C[15:3])  // R7 R4
			sel_n[2] = 1'b0;
	end

	// local register decode from captured low bits and selects
	always @*
	begin
		port_idx = 4'h0;
		is_dir = cap_addr_q[0];
		hit = 1'b0;
		if (!cap_sel_n_q[0])
		begin
			port_idx = {2'b00, cap_addr_q[2:1]};
			hit = 1'b1;
		end
		else if (!cap_sel_n_q[1])
		begin
			// control and pull-up words are served by the readback mux
			case (cap_addr_q[2:1])
				2'h0: port_idx = 4'h0;
				2'h1: port_idx = 4'h0;
				2'h2: port_idx = 4'h6;
				2'h3: port_idx = 4'h5;
				default: port_idx = 4'h0;
			endcase
			hit = cap_addr_q[2];
		end
		else if (!cap_sel_n_q[2])
		begin
			case (cap_addr_q[2:1])
				2'h0: port_idx = 4'h4;
				2'h1: port_idx = 4'h7;
				2'h2: port_idx = 4'h8;
				2'h3: port_idx = 4'h0;  // unmapped pair reads 00
				default: port_idx = 4'h0;
			endcase
			hit = (cap_addr_q[2:1] != 2'h3);
		end
	end

	// output bits read back the latch, input bits the synchronised pin
	always @*
	begin
		rd_val = 8'h00;
		if (!cap_sel_n_q[1] && cap_addr_q == 3'h0)
			rd_val = ptc_q;
		else if (!cap_sel_n_q[1] && cap_addr_q == 3'h2)
			rd_val = pup_q;
		else if (hit && is_dir)
			rd_val = dir_q[port_idx];
		else if (hit)
			rd_val = (data_q[port_idx] & dir_q[port_idx]) |  // R10
				(pin_s_q[port_idx*8 +: 8] & ~dir_q[port_idx]);
	end

	// port 7 is held eight bits wide; its unbonded bits just read back
	generate
		for (gi = 0; gi < NPORT; gi = gi + 1)
		begin : g_flat
			assign lat_flat[gi*8 +: 8] = data_q[gi];
			assign dir_flat[gi*8 +: 8] = dir_q[gi];
		end
	endgenerate

	// second-function overrides per pin
	always @*
	begin
		fn_en = 72'h0;
		fn_val = 72'h0;
		fn_oe = 72'h0;

		// bus modes hand ports 0 to 2 and port 3 bits 0,3-7 to the external bus
		if (bus_mode)
		begin
			fn_en[15:0] = 16'hFFFF;  // R13
			fn_val[15:0] = ext_addr_in;  // R13
			fn_oe[15:0] = 16'hFFFF;  // R13
			fn_en[23:16] = 8'hFF;  // R14
			fn_val[23:16] = ext_data_in;  // R14
			fn_oe[23:16] = {8{ext_data_oe_in}};  // R14
			fn_en[24] = 1'b1;  // R13
			fn_val[24] = ext_ctrl_in[0];
			fn_oe[24] = ext_ctrl_oe_in[0];
			fn_en[31:27] = 5'h1F;  // R13
			fn_val[31:27] = ext_ctrl_in[5:1];
			fn_oe[31:27] = ext_ctrl_oe_in[5:1];
			// bank strobe is active low during the extended cycle
			if (ext_bank_enable_in)
			begin
				fn_en[32] = 1'b1;  // R16
				fn_val[32] = ~ext_bank_cycle_in;  // R16
				fn_oe[32] = 1'b1;
			end
		end

		// port 4: interrupt pins stay inputs, timer pins follow their mode
		if (irq_enable_in[0])
			fn_en[33] = 1'b1;  // R17
		if (irq_enable_in[1])
			fn_en[34] = 1'b1;  // R17
		fn_en[35] = 1'b1;  // R18
		fn_val[35] = t1_pulse_in;
		fn_oe[35] = t1_out_mode_in;  // R18
		fn_en[36] = 1'b1;  // R19
		fn_val[36] = t2_pulse_in;
		fn_oe[36] = t2_out_mode_in;  // R19

		// port 5 low bits: the oscillator owns them when on, else bit 1 may carry the combined timer pulse
		if (sub_clock_on_in)
			fn_en[41:40] = 2'h3;  // R20
		else if (t12_out_en_in)
		begin
			fn_en[41] = 1'b1;  // R20
			fn_val[41] = t12_pulse_in;
			fn_oe[41] = 1'b1;
		end

		// port 5 high bits: host interface flags and strobes
		if (host_if_ctrl_in[0])
		begin
			fn_en[42] = 1'b1;  // R21
			fn_val[42] = host_outbuf_full_in;
			fn_oe[42] = 1'b1;
		end
		if (host_if_ctrl_in[1])
		begin
			fn_en[43] = 1'b1;  // R21
			fn_val[43] = ~host_inbuf_full_in;  // R21
			fn_oe[43] = 1'b1;
		end
		if (host_if_ctrl_in[6])
			fn_en[47:44] = 4'hF;  // R22
	end

	// pins sampled through two flops, phase strobes edge-detected (same domain)
	always @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sync1_q <= 72'h0;
			pin_s_q <= 72'h0;
			ph1_d1_q <= 1'b0;
			ph2_d1_q <= 1'b0;
		end
		else if (clk_en_in)
		begin
			sync1_q <= pin_in;
			pin_s_q <= sync1_q;
			ph1_d1_q <= first_phase_clock_in;  // R23
			ph2_d1_q <= second_phase_clock_in;  // R23
		end
	end

	// bus capture, register writes, and registered pin/feature outputs
	always @(posedge mclk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			for (i = 0; i < NPORT; i = i + 1)
			begin
				data_q[i] <= `GPB_RST_VAL;
				dir_q[i] <= `GPB_RST_VAL;  // R9
			end
			ptc_q <= `GPB_RST_VAL;
			pup_q <= `GPB_RST_VAL;
			cap_addr_q <= 3'h0;
			cap_rd_q <= 1'b1;
			cap_val_n_q <= 1'b1;
			cap_sel_n_q <= 3'h7;
			internal_data_bus_out <= 8'h00;
			internal_data_bus_oe_out <= 1'b0;
			pin_out <= 72'h0;
			pin_oe_out <= 72'h0;
			ext_data_out <= 8'h00;
			ext_irq_out <= 2'h0;
			t1_irq_out <= 1'b0;
			t1_pin_out <= 1'b0;
			t2_pin_out <= 1'b0;
			wake_out <= 1'b0;
			p2_cmos_level_out <= 1'b0;
			p2_pullup_out <= 8'h00;
			host_strobes_out <= 4'hF;
		end
		else if (clk_en_in)
		begin
			if (ph1_rise)
			begin
				cap_addr_q <= internal_address_bus_in[2:0];  // R1
				cap_rd_q <= rd_wr_in;  // R1 R2
				cap_val_n_q <= access_valid_n_in;  // R1 R2
				cap_sel_n_q <= sel_n;  // R1
			end

			// drive read data once decode of the captured cycle is ready
			internal_data_bus_oe_out <= rd_go;  // R6
			internal_data_bus_out <= rd_val;  // R6 R3

			// phase two closes the cycle whether or not it wrote
			if (wr_go)
			begin
				cap_val_n_q <= 1'b1;
				if (!cap_sel_n_q[1] && cap_addr_q == 3'h0)
					ptc_q <= internal_data_bus_in;  // R3 R5
				else if (!cap_sel_n_q[1] && cap_addr_q == 3'h2)
					pup_q <= internal_data_bus_in;
				else if (hit && is_dir)
					dir_q[port_idx] <= internal_data_bus_in;  // R3 R5
				else if (hit)
					data_q[port_idx] <= internal_data_bus_in;  // R11
			end
			else if (ph2_rise)
				cap_val_n_q <= 1'b1;

			// pins follow the registers one cycle later
			pin_out <= (fn_en & fn_val) | (~fn_en & lat_flat);  // R12
			pin_oe_out <= (fn_en & fn_oe) | (~fn_en & dir_flat);  // R8 R11 R12
			ext_data_out <= pin_s_q[23:16];

			// feature outputs, all but the port 2 level and pull-up outputs from synchronised pins
			ext_irq_out <= irq_enable_in & irq_lvl;  // R17
			t1_irq_out <= t1_irq_enable_in && !t1_out_mode_in &&
				(pin_s_q[35] == t1_polarity_in);  // R18
			t1_pin_out <= pin_s_q[35];
			t2_pin_out <= pin_s_q[36];  // R19
			// key-on wakes only outside the two bus modes
			wake_out <= !bus_mode && low_power_in && |key_low;  // R14
			p2_cmos_level_out <= ptc_q[`GPB_PTC_P2_LVL];  // R15
			p2_pullup_out <= pup_q;
			host_strobes_out <= host_if_ctrl_in[6] ? pin_s_q[47:44] : 4'hF;  // R22
		end
	end
endmodule // gpb_port_bank
`default_nettype wire

//--- tb/gpb_bus_cpu.sv
// cpu-side master: makes both phase strobes and runs one transfer at a time
`default_nettype none
module gpb_bus_cpu (
	input  wire logic        clk_in,    // system clock
	output var  logic        ph1_out,   // phase one strobe
	output var  logic        ph2_out,   // phase two strobe
	output var  logic [15:0] addr_out,  // address
	output var  logic        rd_wr_out, // read high
	output var  logic        vld_n_out, // valid low
	output var  logic [7:0]  wdat_out,  // write data
	input  wire logic [7:0]  rdat_in,   // read data
	input  wire logic        roe_in     // read drive
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {ph1_out, ph2_out, vld_n_out, rd_wr_out, addr_out, wdat_out} = 28'h3000000;
	// q is {drive, data} seen just before the closing phase two
	task xfer(input logic rd, input logic [15:0] a, input logic [7:0] d, input logic v,
		output logic [8:0] q);
		@(posedge clk_in);
		ph2_out <= 1'b1;
		addr_out <= a;
		rd_wr_out <= rd;
		vld_n_out <= !v;
		@(posedge clk_in);
		ph2_out <= 1'b0;
		@(posedge clk_in);
		ph1_out <= 1'b1;
		wdat_out <= rd ? ~wdat_out : d;
		@(posedge clk_in);
		ph1_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		q = {roe_in, rdat_in};
		@(posedge clk_in);
		ph2_out <= 1'b1;
		vld_n_out <= 1'b1;
		@(posedge clk_in);
		ph2_out <= 1'b0;
	endtask
endmodule // gpb_bus_cpu
`default_nettype wire

//--- tb/gpb_port_bank_chk.sv
// concurrent checks on the port bank's bus answer and pin muxing
`default_nettype none
module gpb_port_bank_chk (
	input wire logic        mclk_in,                  // clock
	input wire logic        rst_b_in,                 // reset, low
	input wire logic        first_phase_clock_in,     // phase one
	input wire logic        second_phase_clock_in,    // phase two
	input wire logic        rd_wr_in,                 // read high
	input wire logic        access_valid_n_in,        // valid low
	input wire logic [1:0]  proc_mode_in,             // mode
	input wire logic [15:0] ext_addr_in,              // bus address
	input wire logic        ext_bank_enable_in,       // bank enable
	input wire logic        ext_bank_cycle_in,        // bank cycle
	input wire logic [7:0]  host_if_ctrl_in,          // host control
	input wire logic        host_outbuf_full_in,      // out full
	input wire logic [71:0] pin_in,                   // pin levels
	input wire logic [71:0] pin_out,                  // pin drive
	input wire logic [71:0] pin_oe_out,               // pin enable
	input wire logic        internal_data_bus_oe_out, // read drive
	input wire logic        wake_out,                 // wake
	input wire logic [3:0]  host_strobes_out          // host strobes
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_rd_cap;
		$rose(first_phase_clock_in) && rd_wr_in && !access_valid_n_in;
	endsequence
	sequence s_close;
		$rose(second_phase_clock_in);
	endsequence
	a_read_drive: assert property (s_rd_cap |-> ##[1:3] internal_data_bus_oe_out)
		else $error("read not answered");
	a_drop_close: assert property (s_close |-> ##[1:2] !internal_data_bus_oe_out)
		else $error("read drive held past phase two");
	a_write_quiet: assert property ($rose(first_phase_clock_in)
		&& (!rd_wr_in || access_valid_n_in) |-> ##1 !internal_data_bus_oe_out [*3])
		else $error("data bus driven outside a read");
	a_reset_inputs: assert property ($rose(rst_b_in) |-> pin_oe_out[31:0] == 32'h0)
		else $error("pins not inputs after reset");
	a_bus_addr: assert property ((proc_mode_in != 2'h0 && $stable(ext_addr_in)) [*3]
		|-> pin_out[15:0] == ext_addr_in && &pin_oe_out[15:0])
		else $error("address not on ports zero and one");
	a_bank_strobe: assert property ((proc_mode_in != 2'h0 && ext_bank_enable_in
		&& $stable(ext_bank_cycle_in)) [*3] |-> pin_out[32] == !ext_bank_cycle_in && pin_oe_out[32])
		else $error("bank strobe wrong");
	a_host_flag: assert property ((host_if_ctrl_in[0] && $stable(host_outbuf_full_in)) [*3]
		|-> pin_out[42] == host_outbuf_full_in && pin_oe_out[42])
		else $error("out buffer flag wrong");
	a_host_off: assert property (!host_if_ctrl_in[6] [*3] |-> host_strobes_out == 4'hF)
		else $error("host strobes active while off");
	a_host_on: assert property ((host_if_ctrl_in[6] && $stable(pin_in[47:44])) [*6]
		|-> host_strobes_out == pin_in[47:44])
		else $error("host strobes not from pins");
	a_wake_bus: assert property (proc_mode_in != 2'h0 [*3] |-> !wake_out)
		else $error("wake in bus mode");
endmodule // gpb_port_bank_chk
bind gpb_port_bank gpb_port_bank_chk u_gpb_port_bank_chk (.*);
`default_nettype wire

//--- tb/test_gpb_port_bank.sv
// self-checking bench for the port bank
`default_nettype none
module test_gpb_port_bank;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_in = 0, rst_b_in = 0, clk_en_in = 1, ext_data_oe_in = 0;
	logic        first_phase_clock_in, second_phase_clock_in, rd_wr_in, access_valid_n_in;
	logic [15:0] internal_address_bus_in;
	logic [7:0]  internal_data_bus_in, internal_data_bus_out, ext_data_out, p2_pullup_out;
	logic        internal_data_bus_oe_out, t1_irq_out, t1_pin_out, t2_pin_out;
	logic        wake_out, p2_cmos_level_out;
	logic [71:0] pin_out, pin_oe_out, pin_in = {9{8'h5A}};
	logic [1:0]  ext_irq_out, proc_mode_in = 0, irq_enable_in = 0, irq_polarity_in = 0;
	logic [3:0]  host_strobes_out;
	logic        ext_bank_enable_in = 0, ext_bank_cycle_in = 0, low_power_in = 0;
	logic        t1_out_mode_in = 0, t1_pulse_in = 0, t1_polarity_in = 0, t1_irq_enable_in = 0;
	logic        t2_out_mode_in = 0, t2_pulse_in = 0, sub_clock_on_in = 0;
	logic        t12_out_en_in = 0, t12_pulse_in = 0;
	logic        host_outbuf_full_in = 0, host_inbuf_full_in = 0;
	logic [15:0] ext_addr_in = 0;
	logic [5:0]  ext_ctrl_in = 0, ext_ctrl_oe_in = 0;
	logic [7:0]  ext_data_in = 0, host_if_ctrl_in = 0;
	logic [7:0]  m [0:31] = '{default: 8'h00};
	logic [19:0] rows [0:8] = '{20'h009F0, 20'h008A5, 20'h6150F, 20'h6143C, 20'h81DFF,
		20'h81C96, 20'hF1040, 20'hF1281, 20'hF11FF};
	int          num_errors = 0, samples_checked = 0;
	gpb_port_bank u_gpb_port_bank (.*);
	gpb_bus_cpu u_gpb_bus_cpu (.clk_in(mclk_in), .ph1_out(first_phase_clock_in),
		.ph2_out(second_phase_clock_in), .addr_out(internal_address_bus_in),
		.rd_wr_out(rd_wr_in), .vld_n_out(access_valid_n_in), .wdat_out(internal_data_bus_in),
		.rdat_in(internal_data_bus_out), .roe_in(internal_data_bus_oe_out));
	always #25 mclk_in = ~mclk_in;
	task chk(input logic [71:0] got, input logic [71:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task conclude;
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		#200us;
		num_errors++;
		conclude();
	end
	initial
	begin
		logic [8:0] q;
		logic [7:0] a, d, e;
		logic [3:0] p;
		repeat (10) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			{p, a, d} = rows[i];
			m[a] = (a == 8'h11) ? 8'h00 : d;
			u_gpb_bus_cpu.xfer(1'b0, {8'h00, a}, d, 1'b1, q);
			u_gpb_bus_cpu.xfer(1'b1, {8'h00, a}, 8'h00, 1'b1, q);
			e = m[a];
			// input bits read the pin, output bits the latch
			if (!a[0] && a != 8'h10 && a != 8'h12)
				e = (m[a] & m[a | 8'h01]) | (8'h5A & ~m[a | 8'h01]);
			chk(q, {1'b1, e});
			if (p != 4'hF)
			begin
				chk(pin_oe_out[8*p+:8], m[a | 8'h01]);
				chk(pin_out[8*p+:8] & m[a | 8'h01], m[a & 8'hFE] & m[a | 8'h01]);
			end
		end
		chk({p2_cmos_level_out, p2_pullup_out}, 9'h181);
		// high address bits must keep a write away from the bank, as must a dead strobe
		u_gpb_bus_cpu.xfer(1'b0, 16'h0108, 8'h00, 1'b1, q);
		u_gpb_bus_cpu.xfer(1'b0, 16'h0009, 8'h0F, 1'b0, q);
		u_gpb_bus_cpu.xfer(1'b1, 16'h0009, 8'h00, 1'b1, q);
		chk(q, 9'h1F0);
		u_gpb_bus_cpu.xfer(1'b1, 16'h0008, 8'h00, 1'b1, q);
		chk(q, 9'h1AA);
		@(posedge mclk_in);
		{irq_enable_in, irq_polarity_in, t1_irq_enable_in, t1_polarity_in} <= 6'h37;
		{low_power_in, sub_clock_on_in, host_outbuf_full_in, host_inbuf_full_in} <= 4'hF;
		{host_if_ctrl_in, t2_out_mode_in, t2_pulse_in} <= 10'h10F;
		repeat (8) @(negedge mclk_in);
		chk({ext_irq_out, t1_irq_out, t1_pin_out, wake_out}, 5'h1F);
		chk({pin_oe_out[43:40], pin_out[43:42]}, 6'h31);
		chk(ext_data_out, 8'h5A);
		chk({host_strobes_out, pin_oe_out[36], pin_out[36]}, 6'h17);
		@(posedge mclk_in);
		{irq_polarity_in, t1_out_mode_in, t1_pulse_in, t2_out_mode_in} <= 5'h1C;
		{sub_clock_on_in, t12_out_en_in, t12_pulse_in, proc_mode_in} <= 5'h0E;
		{ext_addr_in, ext_bank_enable_in, ext_bank_cycle_in} <= 18'h048D3;
		repeat (8) @(negedge mclk_in);
		chk({ext_irq_out, pin_oe_out[35], pin_out[35], t1_irq_out}, 5'h0C);
		chk({pin_oe_out[41], pin_out[41], pin_oe_out[32], pin_out[32]}, 4'hE);
		chk({pin_oe_out[15:0], pin_out[15:0], wake_out, t2_pin_out}, 34'h3FFFC48D1);
		@(posedge mclk_in);
		{host_if_ctrl_in, proc_mode_in, pin_in} <= 82'h0;
		rst_b_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		for (int i = 8; i < 30; i++)
		begin
			u_gpb_bus_cpu.xfer(1'b1, i[15:0], 8'h00, 1'b1, q);
			chk(q[7:0], 8'h00);
		end
		chk(pin_oe_out[31:0], 32'h0);
		conclude();
	end
endmodule // test_gpb_port_bank
`default_nettype wire
